// [vpir_pkg.sv]
`default_nettype none
package vpir_pkg;

  // i/o port addresses of the two compatibility blocks
  localparam logic [15:0] MONO_BLOCK_BASE      = 16'h03B0;
  localparam logic [15:0] COLOR_BLOCK_BASE     = 16'h03D0;
  localparam logic [15:0] MONO_INDEX_POINTER   = 16'h03B4;
  localparam logic [15:0] MONO_INDEX_DATA      = 16'h03B5;
  localparam logic [15:0] MONO_MODE_CONTROL    = 16'h03B8;
  localparam logic [15:0] MONO_DISPLAY_STATUS  = 16'h03BA;
  localparam logic [15:0] MONO_MASTER_CONFIG   = 16'h03BF;
  localparam logic [15:0] COLOR_INDEX_POINTER  = 16'h03D4;
  localparam logic [15:0] COLOR_INDEX_DATA     = 16'h03D5;
  localparam logic [15:0] COLOR_MODE_CONTROL   = 16'h03D8;
  localparam logic [15:0] COLOR_PALETTE_SELECT = 16'h03D9;
  localparam logic [15:0] COLOR_DISPLAY_STATUS = 16'h03DA;

  // index register map
  localparam int unsigned  NUM_INDEX_REGS      = 38;
  localparam logic [7:0]   IDX_MAX_SCAN_LINE   = 8'h09;
  localparam logic [7:0]   IDX_RESERVED_LO     = 8'h10;
  localparam logic [7:0]   IDX_RESERVED_HI     = 8'h11;
  localparam logic [7:0]   IDX_SCREEN_RESTORE  = 8'h18;
  localparam logic [7:0]   IDX_CONTROL1        = 8'h20;
  localparam logic [7:0]   IDX_LCD_SPECIAL     = 8'h25;

  // field positions
  localparam int unsigned  MODE_BLINK_BIT      = 5;
  localparam int unsigned  MODE_VIDEO_BIT      = 3;
  localparam int unsigned  MONO_GRAPHICS_BIT   = 1;
  localparam int unsigned  CFG_GRAPHICS_BIT    = 0;
  localparam int unsigned  RESTORE_MONO_BIT    = 0;
  localparam int unsigned  RESTORE_FONT2_BIT   = 3;
  localparam int unsigned  CTRL1_SPECIAL_BIT   = 2;
  localparam int unsigned  LCD_RETRACE_EN_BIT  = 0;
  localparam int unsigned  STATUS_RETRACE_BIT  = 3;
  localparam int unsigned  STATUS_QUIET_BIT    = 0;
  localparam logic [7:0]   MONO_MODE_MASK      = 8'h2A;
  localparam logic [4:0]   SHORT_FONT_LAST_ROW = 5'h07;

  // reset values
  localparam logic [7:0]   POINTER_RESET       = 8'h00;
  localparam logic [7:0]   MONO_MODE_RESET     = 8'h00;
  localparam logic         MONO_CFG_RESET      = 1'b0;
  localparam logic [7:0]   COLOR_MODE_RESET    = 8'h00;
  localparam logic [7:0]   PALETTE_RESET       = 8'h00;
  localparam logic [7:0]   INDEX_REG_RESET     = 8'h00;
  localparam logic [7:0]   READ_FILL           = 8'h00;

endpackage : vpir_pkg
`default_nettype wire

// [vpir_index_file.sv]
`timescale 1ns/1ps
`default_nettype none
module vpir_index_file #(
  parameter int unsigned NUM_IDX = vpir_pkg::NUM_INDEX_REGS
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  wr_en,
  input  wire logic [7:0]            wr_idx,
  input  wire logic [7:0]            wr_data,
  input  wire logic [7:0]            rd_idx,
  output logic      [7:0]            rd_data,
  output logic      [NUM_IDX*8-1:0]  regs_flat
);

  // refused at elaboration: the map needs 38 entries, the pointer reaches 256
  if (NUM_IDX < 38 || NUM_IDX > 256)
  begin : g_bad_num_idx
    $error("vpir_index_file: NUM_IDX must lie in 38..256");
  end

  typedef struct packed {
    logic [NUM_IDX-1:0][7:0] regs;
  } vpir_index_state_type;

  vpir_index_state_type state;
  vpir_index_state_type next_state;
  logic [NUM_IDX-1:0]   wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // per-entry write decode; the two reserved slots never take a write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IDX; gi++)
    begin : g_entry
      localparam logic [7:0] IDX = 8'(gi);
      assign wr_hit[gi] = wr_en && (wr_idx == IDX)
                          && (IDX != vpir_pkg::IDX_RESERVED_LO)
                          && (IDX != vpir_pkg::IDX_RESERVED_HI);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state: one shared storage behind both data ports
  always_comb
  begin
    next_state = state;
    for (int i = 0; i < NUM_IDX; i++)
    begin
      if (wr_hit[i])
        next_state.regs[i] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0;
    else if (ce)
      state <= next_state;
  end

  // unimplemented and reserved indexes read as zero
  always_comb
  begin
    rd_data = vpir_pkg::READ_FILL;
    // nine-bit compare so a full 256-entry file still reads back
    if ({1'b0, rd_idx} < 9'(NUM_IDX))
      rd_data = state.regs[rd_idx];
  end

  assign regs_flat = state.regs;

endmodule : vpir_index_file
`default_nettype wire

// [vpir_font_addr.sv]
`timescale 1ns/1ps
`default_nettype none
module vpir_font_addr (
  input  wire logic [7:0]  char_code,
  input  wire logic [3:0]  font_row,
  input  wire logic        tall_font,
  input  wire logic        font2_area,
  input  wire logic        font_bank_select,
  input  wire logic        special_font_select,
  output logic      [14:0] font_addr
);

  logic [2:0] font_row_low_bits;
  logic       font_row_bit3;

  assign font_row_low_bits = font_row[2:0];
  assign font_row_bit3     = font_row[3];

  ////////////////////////////////////////////////////////////////////////////
  // glyph address: rows 8 and up of a tall font sit 2 Kbyte higher
  always_comb
  begin
    font_addr[2:0]  = font_row_low_bits;
    font_addr[10:3] = char_code;
    font_addr[11]   = tall_font ? font_row_bit3
                                : ~font2_area;
    font_addr[12]   = ~font_bank_select;
    font_addr[13]   = ~special_font_select;
    font_addr[14]   = 1'b1;
  end

endmodule : vpir_font_addr
`default_nettype wire

// [vpir_port_regs.sv]
`timescale 1ns/1ps
`default_nettype none
//Contract
//- decode video ports in the 3D0h-3DFh and 3B0h-3BFh i/o blocks
//- one compatibility configuration at a time, colour after reset
//- no light-pen capture; those ports stay unmapped
//- pointers write-only, data read/write, status read-only, per port
//- every index register reachable in both configurations via pointer
//- one index pointer, written from either pointer port
//- either data port reaches the register the shared pointer selects
//- timing registers at 00h-0Fh; 10h and 11h reserved
//- extended registers at 12h-25h, including 18h, 20h and 25h
//- mono mode control write-only, resets to zero, reserved bits zero
//- mono mode bit 5 enables the blinking attribute
//- mono mode bit 3 enables video, zero blanks
//- mono mode bit 1 selects 720x348 graphics over 80x25 text
//- tall fonts take address bit 11 from row bit 3
//- text glyph is addressed by the character code byte
//- font address bit 13 is inverse of control 1 bit 2
//- font address bit 12 is inverse of restore bit 0
module vpir_port_regs #(
  parameter int unsigned NUM_IDX = vpir_pkg::NUM_INDEX_REGS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_sel,
  input  wire logic        vert_retrace,
  input  wire logic        display_quiet,
  input  wire logic [7:0]  fetch_char,
  input  wire logic [3:0]  fetch_row,
  output logic      [14:0] font_addr,
  output logic             mono_active,
  output logic             blink_attr_enable,
  output logic             video_output_enable,
  output logic             mono_graphics_select,
  output logic      [7:0]  color_mode,
  output logic      [7:0]  color_palette
);

  // refused at elaboration: the map needs 38 entries, the pointer reaches 256
  if (NUM_IDX < 38 || NUM_IDX > 256)
  begin : g_bad_num_idx
    $error("vpir_port_regs: NUM_IDX must lie in 38..256");
  end

  typedef struct packed {
    logic [7:0]  pointer;
    logic [7:0]  mono_mode;
    logic        mono_cfg;
    logic [7:0]  color_mode;
    logic [7:0]  palette;
    logic [7:0]  rdata;
    logic [14:0] font_addr;
    logic        mono_active;
    logic        blink;
    logic        video_on;
    logic        graphics;
  } vpir_port_state_type;

  vpir_port_state_type state;
  vpir_port_state_type next_state;

  logic                 in_mono_block;
  logic                 in_color_block;
  logic                 data_port;
  logic                 idx_wr;
  logic [7:0]           idx_rd_data;
  logic [NUM_IDX*8-1:0] idx_flat;
  logic [7:0]           reg_scan;
  logic [7:0]           reg_restore;
  logic [7:0]           reg_ctrl1;
  logic [7:0]           reg_lcd;
  logic                 tall_font;
  logic [14:0]          font_addr_comb;
  logic [7:0]           status_byte;

  ////////////////////////////////////////////////////////////////////////////
  // address decode of the two i/o blocks
  assign in_mono_block  = io_addr[15:4] == vpir_pkg::MONO_BLOCK_BASE[15:4];
  assign in_color_block = io_addr[15:4] == vpir_pkg::COLOR_BLOCK_BASE[15:4];
  assign io_sel         = in_mono_block || in_color_block;
  // both data ports lead to the same storage, in either configuration
  assign data_port = (io_addr == vpir_pkg::MONO_INDEX_DATA)
                  || (io_addr == vpir_pkg::COLOR_INDEX_DATA);
  assign idx_wr    = io_wr && data_port;

  ////////////////////////////////////////////////////////////////////////////
  // indexed storage: timing at 00h-0Fh, extended at 12h-25h
  vpir_index_file #(
    .NUM_IDX   (NUM_IDX)
  ) u_index_file (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .wr_en     (idx_wr),
    .wr_idx    (state.pointer),
    .wr_data   (io_wdata),
    .rd_idx    (state.pointer),
    .rd_data   (idx_rd_data),
    .regs_flat (idx_flat)
  );

  // timing and extended registers that steer this block
  assign reg_scan    = idx_flat[vpir_pkg::IDX_MAX_SCAN_LINE*8 +: 8];
  assign reg_restore = idx_flat[vpir_pkg::IDX_SCREEN_RESTORE*8 +: 8];
  assign reg_ctrl1   = idx_flat[vpir_pkg::IDX_CONTROL1*8 +: 8];
  assign reg_lcd     = idx_flat[vpir_pkg::IDX_LCD_SPECIAL*8 +: 8];

  // more than eight scan lines per row means a tall font
  assign tall_font = reg_scan[4:0] > vpir_pkg::SHORT_FONT_LAST_ROW;

  ////////////////////////////////////////////////////////////////////////////
  // font fetch address, registered below so the output is a clean flop
  vpir_font_addr u_font_addr (
    .char_code           (fetch_char),
    .font_row            (fetch_row),
    .tall_font           (tall_font),
    .font2_area          (reg_restore[vpir_pkg::RESTORE_FONT2_BIT]),
    .font_bank_select    (reg_restore[vpir_pkg::RESTORE_MONO_BIT]),
    .special_font_select (reg_ctrl1[vpir_pkg::CTRL1_SPECIAL_BIT]),
    .font_addr           (font_addr_comb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status byte; the retrace bit shows only when the lcd register allows it
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[vpir_pkg::STATUS_RETRACE_BIT] =
      vert_retrace && reg_lcd[vpir_pkg::LCD_RETRACE_EN_BIT];
    status_byte[vpir_pkg::STATUS_QUIET_BIT] = display_quiet;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port writes; unmapped ports and light-pen ports are ignored
  always_comb
  begin
    next_state = state;
    if (io_wr)
    begin
      case (io_addr)
        vpir_pkg::MONO_INDEX_POINTER,
        vpir_pkg::COLOR_INDEX_POINTER:
          next_state.pointer = io_wdata;
        vpir_pkg::MONO_MODE_CONTROL:
          // reserved bits are held at zero whatever software writes
          next_state.mono_mode = io_wdata & vpir_pkg::MONO_MODE_MASK;
        vpir_pkg::MONO_MASTER_CONFIG:
          next_state.mono_cfg = io_wdata[vpir_pkg::CFG_GRAPHICS_BIT];
        vpir_pkg::COLOR_MODE_CONTROL:
          next_state.color_mode = io_wdata;
        vpir_pkg::COLOR_PALETTE_SELECT:
          next_state.palette = io_wdata;
        default:
          next_state.pointer = state.pointer;
      endcase
    end

    // reads: write-only ports answer zero and touch nothing
    if (io_rd)
    begin
      case (io_addr)
        vpir_pkg::MONO_INDEX_DATA,
        vpir_pkg::COLOR_INDEX_DATA:
          next_state.rdata = idx_rd_data;
        vpir_pkg::MONO_DISPLAY_STATUS,
        vpir_pkg::COLOR_DISPLAY_STATUS:
          next_state.rdata = status_byte;
        vpir_pkg::COLOR_MODE_CONTROL:
          next_state.rdata = state.color_mode;
        vpir_pkg::COLOR_PALETTE_SELECT:
          next_state.rdata = state.palette;
        default:
          next_state.rdata = vpir_pkg::READ_FILL;
      endcase
    end

    // exactly one configuration: restore bit 0 set picks mono, else colour
    next_state.mono_active =
      reg_restore[vpir_pkg::RESTORE_MONO_BIT];

    // display controls follow the mode register of the live configuration
    if (next_state.mono_active)
    begin
      next_state.blink =
        next_state.mono_mode[vpir_pkg::MODE_BLINK_BIT];
      next_state.video_on =
        next_state.mono_mode[vpir_pkg::MODE_VIDEO_BIT];
    end
    else
    begin
      next_state.blink =
        next_state.color_mode[vpir_pkg::MODE_BLINK_BIT];
      next_state.video_on =
        next_state.color_mode[vpir_pkg::MODE_VIDEO_BIT];
    end

    // the master config bit overrides a graphics request in the mode register
    next_state.graphics = next_state.mono_active
      && next_state.mono_mode[vpir_pkg::MONO_GRAPHICS_BIT]
      && next_state.mono_cfg;

    next_state.font_addr = font_addr_comb;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; all state freezes while ce is low
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state             <= '0;
      state.pointer     <= vpir_pkg::POINTER_RESET;
      state.mono_mode   <= vpir_pkg::MONO_MODE_RESET;
      state.mono_cfg    <= vpir_pkg::MONO_CFG_RESET;
      state.color_mode  <= vpir_pkg::COLOR_MODE_RESET;
      state.palette     <= vpir_pkg::PALETTE_RESET;
      state.rdata       <= vpir_pkg::READ_FILL;
      state.mono_active <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign io_rdata             = state.rdata;
  assign font_addr            = state.font_addr;
  assign mono_active          = state.mono_active;
  assign blink_attr_enable    = state.blink;
  assign video_output_enable  = state.video_on;
  assign mono_graphics_select = state.graphics;
  assign color_mode           = state.color_mode;
  assign color_palette        = state.palette;

endmodule : vpir_port_regs
`default_nettype wire

// [vpir_port_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module vpir_port_regs_properties #(
  parameter int unsigned NUM_IDX = vpir_pkg::NUM_INDEX_REGS
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_sel,
  input wire logic        vert_retrace,
  input wire logic        display_quiet,
  input wire logic [7:0]  fetch_char,
  input wire logic [3:0]  fetch_row,
  input wire logic [14:0] font_addr,
  input wire logic        mono_active,
  input wire logic        blink_attr_enable,
  input wire logic        video_output_enable,
  input wire logic        mono_graphics_select,
  input wire logic [7:0]  color_mode,
  input wire logic [7:0]  color_palette
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // pointer write then data write, back to back or one idle cycle apart
  sequence s_idx(logic [7:0] idx);
    ce && io_wr && io_sel && io_addr[3:0] == 4'h4 && io_wdata == idx
    ##[1:2] ce && io_wr && io_sel && io_addr[3:0] == 4'h5;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  property p_sel;
    io_sel == (io_addr[15:4] == 12'h03B || io_addr[15:4] == 12'h03D);
  endproperty
  a_sel: assert property (p_sel) else $error("decode wrong");
  // write-only, light-pen and unmapped ports must read as zero
  property p_wo_read;
    ce && io_rd && (!io_sel || io_addr inside {16'h03B4, 16'h03B8,
      16'h03BF, 16'h03D4, 16'h03DB, 16'h03DC}) |=> io_rdata == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("nonzero");
  property p_mode;
    ce && io_wr && io_addr == 16'h03B8 |=> !mono_active ||
      (blink_attr_enable == $past(io_wdata[5]) &&
       video_output_enable == $past(io_wdata[3]));
  endproperty
  a_mode: assert property (p_mode) else $error("mono mode");
  property p_color;
    ce && io_wr && io_addr == 16'h03D8 |=> color_mode == $past(io_wdata);
  endproperty
  a_color: assert property (p_color) else $error("colour mode");
  // glyph address tracks the fetch inputs one edge later
  property p_fetch;
    $past(arst_n) && $past(ce) |-> font_addr[14] &&
      font_addr[10:0] == {$past(fetch_char), $past(fetch_row[2:0])};
  endproperty
  a_fetch: assert property (p_fetch) else $error("font addr");
  property p_status;
    ce && io_rd && io_addr inside {16'h03BA, 16'h03DA} |=>
      (io_rdata & 8'hF7) == {7'h00, $past(display_quiet)};
  endproperty
  a_status: assert property (p_status) else $error("status");
  property p_special;
    s_idx(8'h20) ##1 ce |=> font_addr[13] == !$past(io_wdata[2], 2);
  endproperty
  a_special: assert property (p_special) else $error("special");
  property p_bank;
    s_idx(8'h18) ##1 ce |=> font_addr[12] == !$past(io_wdata[0], 2) &&
      mono_active == $past(io_wdata[0], 2);
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_mgfx;
    mono_graphics_select |-> mono_active;
  endproperty
  a_mgfx: assert property (p_mgfx) else $error("graphics");
endmodule : vpir_port_regs_properties

bind vpir_port_regs vpir_port_regs_properties #(.NUM_IDX(NUM_IDX)) chk_inst (
  .clk(clk), .arst_n(arst_n), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_sel(io_sel),
  .vert_retrace(vert_retrace), .display_quiet(display_quiet),
  .fetch_char(fetch_char), .fetch_row(fetch_row), .font_addr(font_addr),
  .mono_active(mono_active), .blink_attr_enable(blink_attr_enable),
  .video_output_enable(video_output_enable),
  .mono_graphics_select(mono_graphics_select), .color_mode(color_mode),
  .color_palette(color_palette));
`default_nettype wire

// [vpir_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vpir_cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  io_rdata,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata
);
  int idle = 0;
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // strobe held across one rising edge; released lines invert so no
  // stale address or data survives the cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask : rd
endmodule : vpir_cpu_model
`default_nettype wire

// [video_port_index_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module video_port_index_regs_bench;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;}
    vpir_row_type;
  logic        clk;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        vert_retrace = 1'b0;
  logic        display_quiet = 1'b0;
  logic [7:0]  fetch_char = 8'h00;
  logic [3:0]  fetch_row = 4'h0;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_sel;
  logic [14:0] font_addr;
  logic        mono_active;
  logic        blink_attr_enable;
  logic        video_output_enable;
  logic        mono_graphics_select;
  logic [7:0]  color_mode;
  logic [7:0]  color_palette;
  logic [7:0]  rv;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  vpir_row_type rows [8] = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h0F, 8'h5A, 8'h5A},
    '{8'h10, 8'hFF, 8'h00}, '{8'h11, 8'hFF, 8'h00}, '{8'h12, 8'h3C, 8'h3C},
    '{8'h25, 8'hC3, 8'hC3}, '{8'h26, 8'h77, 8'h00}, '{8'h09, 8'h0F, 8'h0F}};
  logic [15:0] zero_ports [7] = '{16'h03B4, 16'h03B8, 16'h03BF, 16'h03D4,
    16'h03DB, 16'h03DC, 16'h0300};

  vpir_port_regs vpir_port_regs_inst (.clk(clk), .arst_n(arst_n), .ce(ce),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_sel(io_sel), .vert_retrace(vert_retrace),
    .display_quiet(display_quiet), .fetch_char(fetch_char),
    .fetch_row(fetch_row), .font_addr(font_addr), .mono_active(mono_active),
    .blink_attr_enable(blink_attr_enable),
    .video_output_enable(video_output_enable),
    .mono_graphics_select(mono_graphics_select), .color_mode(color_mode),
    .color_palette(color_palette));
  vpir_cpu_model vpir_cpu_model_inst (.clk(clk), .io_rdata(io_rdata),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ceiling well above the roughly 140 cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] ex);
    samples_checked++;
    if (seen !== ex)
    begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, ex);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    vpir_cpu_model_inst.wr(a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    vpir_cpu_model_inst.rd(a, rv);
  endtask : rd
  // indexed pair; the pointer is shared by both blocks
  task automatic put(input logic [11:0] b, input logic [7:0] i, d);
    wr({b, 4'h4}, i);
    wr({b, 4'h5}, d);
  endtask : put
  task automatic fetch(input logic [3:0] row);
    fetch_row = row;
    fetch_char = 8'h4D;
    repeat (2) @(negedge clk);
  endtask : fetch
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    foreach (rows[i])
    begin
      put(i[0] ? 12'h03B : 12'h03D, rows[i].idx, rows[i].wd);
      wr(i[0] ? 16'h03D4 : 16'h03B4, rows[i].idx);
      rd(i[0] ? 16'h03B5 : 16'h03D5);
      check(rv, rows[i].ex);
    end
    $display("test rows done");
    wr(16'h03D8, 8'hA5);
    rd(16'h03D8);
    check(rv, 8'hA5);
    wr(16'h03D9, 8'h5A);
    rd(16'h03D9);
    check(rv, 8'h5A);
    put(12'h03D, 8'h18, 8'h01);
    wr(16'h03BF, 8'h01);
    wr(16'h03B8, 8'hFF);
    check({mono_active, blink_attr_enable, video_output_enable,
      mono_graphics_select}, 4'hF);
    wr(16'h03B8, 8'h08);
    check(blink_attr_enable, 1'b0);
    check(video_output_enable, 1'b1);
    wr(16'h03BF, 8'h00);
    wr(16'h03B8, 8'h22);
    check({video_output_enable, mono_graphics_select}, 2'b00);
    $display("test mono done");
    foreach (zero_ports[i])
    begin
      rd(zero_ports[i]);
      check(rv, 8'h00);
    end
    check(color_mode, 8'hA5);
    $display("test write-only done");
    vert_retrace = 1'b1;
    display_quiet = 1'b1;
    rd(16'h03BA);
    check(rv, 8'h09);
    vert_retrace = 1'b0;
    rd(16'h03DA);
    check(rv, 8'h01);
    $display("test status done");
    put(12'h03D, 8'h18, 8'h00);
    put(12'h03D, 8'h20, 8'h04);
    for (int k = 1; k < 16; k += 8)
    begin
      fetch(k[3:0]);
      check(font_addr, {4'h5, k[3], 8'h4D, k[2:0]});
    end
    put(12'h03B, 8'h09, 8'h07);
    put(12'h03B, 8'h18, 8'h01);
    fetch(4'h1);
    check(font_addr, {4'h4, 1'b1, 8'h4D, 3'h1});
    $display("test font done");
    ce = 1'b0;
    wr(16'h03D9, 8'h00);
    ce = 1'b1;
    check(color_palette, 8'h5A);
    $display("test hold done");
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    check({color_mode, color_palette}, 16'h0000);
    check({mono_active, blink_attr_enable, video_output_enable}, 3'h0);
    rd(16'h03D5);
    check(rv, 8'h00);
    // mono live again: its mode register must have come back as zero
    put(12'h03B, 8'h18, 8'h01);
    rd(16'h03B5);
    check(rv, 8'h01);
    check({mono_active, blink_attr_enable, video_output_enable,
      mono_graphics_select}, 4'h8);
    $display("test reset done");
    wrap_up();
  end
endmodule : video_port_index_regs_bench
`default_nettype wire
